// file: hdl/analog_sel_pkg.sv
// Package of constants for the analog input pin select block.
// Assumes an 8-bit internal register bus with 16-bit byte addresses and a 25 MHz clock.
package analog_sel_pkg;

  // ----------------------------------------------------------------
  // Register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_CHANNEL_SELECT = 16'hff0e;
  localparam logic [15:0] ADDR_PORT2_DIRECTION = 16'hff22;
  localparam logic [15:0] ADDR_ANALOG_PIN_CONFIG = 16'hff2e;
  localparam logic [15:0] ADDR_AMPLIFIER_CONTROL = 16'hff60;
  localparam logic [7:0] RST_CHANNEL_SELECT = 8'h00;
  localparam logic [7:0] RST_PORT2_DIRECTION = 8'hff;
  localparam logic [7:0] RST_ANALOG_PIN_CONFIG = 8'h00;
  localparam logic [7:0] RST_AMPLIFIER_CONTROL = 8'h00;
  localparam logic [7:0] AMP_CTRL_MASK = 8'hc3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int INTERNAL_REF_PICK_POS = 7;
  localparam int GAIN_AMP_ROUTE_POS = 6;
  localparam int TRIGGER_SOURCE_HI_POS = 5;
  localparam int TRIGGER_SOURCE_LO_POS = 4;
  localparam int CHANNEL_CODE_B3_POS = 3;
  localparam int CHANNEL_CODE_B0_POS = 0;
  localparam int SINGLE_AMP_ENABLE_POS = 7;
  localparam int GAIN_AMP_ENABLE_POS = 6;
  localparam int SHARED_PIN = 1;
  localparam logic [3:0] CHANNEL_CODE_MAX = 4'h8;
  localparam logic [3:0] CHANNEL_CODE_PORT7 = 4'h8;

  // ----------------------------------------------------------------
  // Pin roles, source kinds and trigger codes
  // ----------------------------------------------------------------
  localparam logic [1:0] ROLE_PLAIN = 2'h0;
  localparam logic [1:0] ROLE_AMP_INPUT = 2'h1;
  localparam logic [1:0] ROLE_SHARED = 2'h2;

  typedef enum logic [1:0] {
    SRC_PIN = 2'h0,
    SRC_PGA = 2'h1,
    SRC_REF = 2'h3,
    SRC_BAD = 2'h2
  } source_kind_t;

  localparam logic [1:0] TRIG_SOFTWARE = 2'h0;
  localparam logic [1:0] TRIG_TIMER_X_ZERO = 2'h1;
  localparam logic [1:0] TRIG_TIMER_X_ONE = 2'h2;
  localparam logic [1:0] TRIG_PROHIBITED = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int REF_SETTLE_US = 10;
  localparam int REF_SETTLE_CYCLES = (REF_SETTLE_US * (CLK_HZ / 1000000));
  localparam logic [8:0] REF_SETTLE_COUNT = 9'(REF_SETTLE_CYCLES);

endpackage

// file: hdl/pin_function_decode.sv
// Per-pin function decode for one port 2 pin.
// Assumes registered configuration inputs from the select block; output is purely combinational.
`timescale 1ns/10ps
module pin_function_decode #(
  parameter logic [1:0] ROLE = 2'h0
) (
  input wire logic dir_i,
  input wire logic digital_i,
  input wire logic chan_hit_i,
  input wire logic single_en_i,
  input wire logic gain_en_i,
  input wire logic pga_route_i,
  output logic out_buf_en_o,
  output logic analog_o,
  output logic amp_in_o,
  output logic amp_out_o,
  output logic convert_o,
  output logic bad_o
);

  logic usable;

  // An analog pin is only usable in input mode; output mode would fight the source.
  assign usable = !digital_i && dir_i;
  assign out_buf_en_o = !dir_i;
  assign analog_o = !digital_i;
  assign convert_o = usable && chan_hit_i;

  // Amplifier roles depend on where the pin sits around the amplifier.
  always_comb
  begin
    amp_in_o = 1'b0;
    amp_out_o = 1'b0;
    bad_o = (digital_i && chan_hit_i) || (!digital_i && !dir_i);
    if (ROLE == analog_sel_pkg::ROLE_AMP_INPUT)
    begin
      amp_in_o = usable && single_en_i;
    end
    else if (ROLE == analog_sel_pkg::ROLE_SHARED)
    begin
      amp_in_o = usable && gain_en_i;
      amp_out_o = usable && single_en_i;
      bad_o = bad_o || (digital_i && single_en_i) || (digital_i && gain_en_i && pga_route_i);
    end
  end

endmodule // pin_function_decode

// file: hdl/analog_input_pin_select.sv
// Register file and pin function selection for the analog input path.
// Assumes a byte-wide internal bus whose master holds a write while bus_wait_o is high.
`timescale 1ns/10ps
// Notes on behaviour
// - Channel code picks pins 0..8; others prohibited.
// - Reference pick selects internal 1.2 V reference.
// - Route bit alone selects gain amplifier output.
// - Trigger field picks software, timer zero, one.
// - Channel select write inserts one wait cycle.
// - Channel select resets to zero.
// - Direction resets to ones; bit writes allowed.
// - Direction zero drives output; one is input.
// - Amplifier pins need direction one.
// - Amp inputs: analog, input, enabled; maybe converted.
// - Gain enable makes shared pin gain input.
// - Both enables feed amp output into gain.
// - Enable bits 7, 6; digital shared pin prohibited.
// - Configuration zero analog, one digital.
module analog_input_pin_select (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic bus_bit_i,
  input wire logic [2:0] bus_bit_idx_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic bus_rd_i,
  output logic [7:0] bus_rdata_o,
  output logic bus_wait_o,
  input wire logic conv_run_i,
  input wire logic timer_x_zero_i,
  input wire logic timer_x_one_i,
  output analog_sel_pkg::source_kind_t src_kind_o,
  output logic [3:0] src_channel_o,
  output logic [1:0] trigger_sel_o,
  output logic trigger_err_o,
  output logic conv_start_o,
  output logic ref_ready_o,
  output logic [7:0] pin_out_buf_en_o,
  output logic [7:0] pin_analog_o,
  output logic [7:0] pin_amp_in_o,
  output logic pin_amp_out_o,
  output logic [7:0] pin_convert_o,
  output logic port7_convert_o,
  output logic config_err_o
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [7:0] chan_sel_q;
  logic [7:0] dir_q;
  logic [7:0] cfg_q;
  logic [7:0] amp_q;
  logic wait_q;
  logic waited_wr;
  logic commit;
  logic [3:0] code;

  // Writes that stall the bus must be held by the master for a second cycle.
  assign waited_wr = bus_wr_i && (bus_addr_i == analog_sel_pkg::ADDR_CHANNEL_SELECT ||
                                  bus_addr_i == analog_sel_pkg::ADDR_ANALOG_PIN_CONFIG);
  assign bus_wait_o = waited_wr && !wait_q;
  assign commit = bus_wr_i && !bus_wait_o;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      wait_q <= 1'b0;
    else
      wait_q <= bus_wait_o;
  end

  // Merge a byte write or a single-bit write into the old register value.
  function automatic logic [7:0] merge(input logic [7:0] old);
    logic [7:0] r;
    r = old;
    if (bus_bit_i)
      r[bus_bit_idx_i] = bus_wdata_i[0];
    else
      r = bus_wdata_i;
    return r;
  endfunction

  // Register storage, one process per register.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      chan_sel_q <= analog_sel_pkg::RST_CHANNEL_SELECT;
    else if (commit && bus_addr_i == analog_sel_pkg::ADDR_CHANNEL_SELECT)
      chan_sel_q <= merge(chan_sel_q);
  end
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      dir_q <= analog_sel_pkg::RST_PORT2_DIRECTION;
    else if (commit && bus_addr_i == analog_sel_pkg::ADDR_PORT2_DIRECTION)
      dir_q <= merge(dir_q);
  end
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      cfg_q <= analog_sel_pkg::RST_ANALOG_PIN_CONFIG;
    else if (commit && bus_addr_i == analog_sel_pkg::ADDR_ANALOG_PIN_CONFIG)
      cfg_q <= merge(cfg_q);
  end

  // Amplifier control bits 5..2 are not stored, so they read back as zero.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      amp_q <= analog_sel_pkg::RST_AMPLIFIER_CONTROL;
    else if (commit && bus_addr_i == analog_sel_pkg::ADDR_AMPLIFIER_CONTROL)
      amp_q <= merge(amp_q) & analog_sel_pkg::AMP_CTRL_MASK;
  end

  // Read data is registered; an unmapped address answers zero.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      bus_rdata_o <= 8'h00;
    else if (bus_rd_i)
    begin
      unique case (bus_addr_i)
        analog_sel_pkg::ADDR_CHANNEL_SELECT: bus_rdata_o <= chan_sel_q;
        analog_sel_pkg::ADDR_PORT2_DIRECTION: bus_rdata_o <= dir_q;
        analog_sel_pkg::ADDR_ANALOG_PIN_CONFIG: bus_rdata_o <= cfg_q;
        analog_sel_pkg::ADDR_AMPLIFIER_CONTROL: bus_rdata_o <= amp_q;
        default: bus_rdata_o <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Converter source and trigger selection
  // ----------------------------------------------------------------
  assign code = chan_sel_q[analog_sel_pkg::CHANNEL_CODE_B3_POS:analog_sel_pkg::CHANNEL_CODE_B0_POS];

  // The reference pick has priority over the route bit and the channel code.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      src_kind_o <= analog_sel_pkg::SRC_PIN;
      src_channel_o <= 4'h0;
    end
    else
    begin
      src_channel_o <= code;
      if (chan_sel_q[analog_sel_pkg::INTERNAL_REF_PICK_POS])
        src_kind_o <= analog_sel_pkg::SRC_REF;
      else if (chan_sel_q[analog_sel_pkg::GAIN_AMP_ROUTE_POS])
        src_kind_o <= analog_sel_pkg::SRC_PGA;
      else if (code <= analog_sel_pkg::CHANNEL_CODE_MAX)
        src_kind_o <= analog_sel_pkg::SRC_PIN;
      else
        src_kind_o <= analog_sel_pkg::SRC_BAD;
    end
  end

  logic [1:0] trig;
  logic run_q;
  assign trig = chan_sel_q[analog_sel_pkg::TRIGGER_SOURCE_HI_POS:analog_sel_pkg::TRIGGER_SOURCE_LO_POS];

  // Software mode starts on the rising edge of the run bit; timer modes follow the timer while running.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      trigger_sel_o <= analog_sel_pkg::TRIG_SOFTWARE;
      trigger_err_o <= 1'b0;
      conv_start_o <= 1'b0;
      run_q <= 1'b0;
    end
    else
    begin
      run_q <= conv_run_i;
      trigger_sel_o <= trig;
      trigger_err_o <= (trig == analog_sel_pkg::TRIG_PROHIBITED);
      unique case (trig)
        analog_sel_pkg::TRIG_SOFTWARE: conv_start_o <= conv_run_i && !run_q;
        analog_sel_pkg::TRIG_TIMER_X_ZERO: conv_start_o <= conv_run_i && timer_x_zero_i;
        analog_sel_pkg::TRIG_TIMER_X_ONE: conv_start_o <= conv_run_i && timer_x_one_i;
        default: conv_start_o <= 1'b0;
      endcase
    end
  end

  // Settling status for the internal reference, so software can poll instead of timing it.
  logic [8:0] settle_q;
  always_ff @(posedge clk_i)
  begin
    if (reset_i || !chan_sel_q[analog_sel_pkg::INTERNAL_REF_PICK_POS])
      settle_q <= 9'h000;
    else if (settle_q != analog_sel_pkg::REF_SETTLE_COUNT)
      settle_q <= settle_q + 9'h001;
  end
  assign ref_ready_o = (settle_q == analog_sel_pkg::REF_SETTLE_COUNT);

  // ----------------------------------------------------------------
  // Pin function decode
  // ----------------------------------------------------------------
  logic single_en;
  logic gain_en;
  logic pin_route;
  logic [7:0] out_en_d;
  logic [7:0] analog_d;
  logic [7:0] amp_in_d;
  logic [7:0] convert_d;
  logic [7:0] bad_d;
  logic [7:0] amp_out_d;

  assign single_en = amp_q[analog_sel_pkg::SINGLE_AMP_ENABLE_POS];
  assign gain_en = amp_q[analog_sel_pkg::GAIN_AMP_ENABLE_POS];
  assign pin_route = !chan_sel_q[analog_sel_pkg::INTERNAL_REF_PICK_POS] &&
                     !chan_sel_q[analog_sel_pkg::GAIN_AMP_ROUTE_POS];

  for (genvar n = 0; n < 8; n++)
  begin : g_pin
    localparam logic [1:0] ROLE = (n == analog_sel_pkg::SHARED_PIN) ? analog_sel_pkg::ROLE_SHARED :
                                  (n == 0 || n == 2) ? analog_sel_pkg::ROLE_AMP_INPUT :
                                  analog_sel_pkg::ROLE_PLAIN;
    pin_function_decode #(.ROLE(ROLE)) u_dec (
      .dir_i(dir_q[n]),
      .digital_i(cfg_q[n]),
      .chan_hit_i(pin_route && code == 4'(n)),
      .single_en_i(single_en),
      .gain_en_i(gain_en),
      .pga_route_i(!chan_sel_q[analog_sel_pkg::INTERNAL_REF_PICK_POS] &&
                   chan_sel_q[analog_sel_pkg::GAIN_AMP_ROUTE_POS]),
      .out_buf_en_o(out_en_d[n]),
      .analog_o(analog_d[n]),
      .amp_in_o(amp_in_d[n]),
      .amp_out_o(amp_out_d[n]),
      .convert_o(convert_d[n]),
      .bad_o(bad_d[n])
    );
  end

  // Pin controls are registered so the analog switches see glitch-free levels.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pin_out_buf_en_o <= 8'h00;
      pin_analog_o <= 8'h00;
      pin_amp_in_o <= 8'h00;
      pin_amp_out_o <= 1'b0;
      pin_convert_o <= 8'h00;
      port7_convert_o <= 1'b0;
      config_err_o <= 1'b0;
    end
    else
    begin
      pin_out_buf_en_o <= out_en_d;
      pin_analog_o <= analog_d;
      pin_amp_in_o <= amp_in_d;
      pin_amp_out_o <= amp_out_d[analog_sel_pkg::SHARED_PIN];
      pin_convert_o <= convert_d;
      port7_convert_o <= pin_route && code == analog_sel_pkg::CHANNEL_CODE_PORT7;
      config_err_o <= (|bad_d) || (pin_route && code > analog_sel_pkg::CHANNEL_CODE_MAX);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_chansel_reset_zero: assert property (@(posedge clk_i) reset_i |=> chan_sel_q == 8'h00)
    else $error("channel select not zero after reset");
  a_dir_reset_ones: assert property (@(posedge clk_i) reset_i |=> dir_q == 8'hff)
    else $error("direction not all ones after reset");
  a_ref_has_priority: assert property (@(posedge clk_i) disable iff (reset_i)
    chan_sel_q[7] |=> src_kind_o == analog_sel_pkg::SRC_REF)
    else $error("reference pick did not select reference");
  a_pga_route_sel: assert property (@(posedge clk_i) disable iff (reset_i)
    !chan_sel_q[7] && chan_sel_q[6] |=> src_kind_o == analog_sel_pkg::SRC_PGA)
    else $error("route bit did not select gain amplifier");
  a_channel_pin_sel: assert property (@(posedge clk_i) disable iff (reset_i)
    chan_sel_q[7:6] == 2'h0 && chan_sel_q[3:0] <= 4'h8 |=>
    src_kind_o == analog_sel_pkg::SRC_PIN && src_channel_o == $past(chan_sel_q[3:0]))
    else $error("channel code did not select its pin");
  a_trigger_bad_code: assert property (@(posedge clk_i) disable iff (reset_i)
    chan_sel_q[5:4] == 2'h3 |=> trigger_err_o && !conv_start_o)
    else $error("prohibited trigger code not flagged");
  a_wait_one_cycle: assert property (@(posedge clk_i) disable iff (reset_i)
    bus_wr_i && bus_addr_i == 16'hff0e && !wait_q |-> bus_wait_o ##1 (!bus_wait_o && chan_sel_q == $past(chan_sel_q)))
    else $error("channel select write wait is not one cycle");
  a_dir_out_buffer: assert property (@(posedge clk_i) disable iff (reset_i)
    ##1 pin_out_buf_en_o == ~$past(dir_q))
    else $error("output buffer does not follow direction");
  a_shared_digital_amp: assert property (@(posedge clk_i) disable iff (reset_i)
    cfg_q[1] && amp_q[7] |=> config_err_o && !pin_amp_out_o)
    else $error("amplifier on digital shared pin not flagged");
endmodule // analog_input_pin_select

// file: dv/tb.sv
// Self-checking bench for the analog input pin select block.
// Assumes the design package is compiled first; the bench drives every input at falling edges.
`timescale 1ns/10ps
module tb;
  // ------------------------------------------------------------
  // Stimulus signals, clock and design instance
  // ------------------------------------------------------------
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [15:0] bus_addr_i = 16'h0000;
  logic bus_wr_i = 1'b0;
  logic bus_bit_i = 1'b0;
  logic [2:0] bus_bit_idx_i = 3'h0;
  logic [7:0] bus_wdata_i = 8'h00;
  logic bus_rd_i = 1'b0;
  logic conv_run_i = 1'b0;
  logic timer_x_zero_i = 1'b0;
  logic timer_x_one_i = 1'b0;
  logic [7:0] bus_rdata_o;
  logic bus_wait_o;
  analog_sel_pkg::source_kind_t src_kind_o;
  logic [3:0] src_channel_o;
  logic [1:0] trigger_sel_o;
  logic trigger_err_o;
  logic conv_start_o;
  logic ref_ready_o;
  logic [7:0] pin_out_buf_en_o;
  logic [7:0] pin_analog_o;
  logic [7:0] pin_amp_in_o;
  logic pin_amp_out_o;
  logic [7:0] pin_convert_o;
  logic port7_convert_o;
  logic config_err_o;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int waits = 0;
  int cnt = 0;

  // The clock toggles every 20 ns, half of its 40 ns period.
  always #20 clk_i = ~clk_i;

  analog_input_pin_select analog_input_pin_select_i (
    .clk_i(clk_i), .reset_i(reset_i), .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i), .bus_bit_i(bus_bit_i),
    .bus_bit_idx_i(bus_bit_idx_i), .bus_wdata_i(bus_wdata_i), .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o),
    .bus_wait_o(bus_wait_o), .conv_run_i(conv_run_i), .timer_x_zero_i(timer_x_zero_i),
    .timer_x_one_i(timer_x_one_i), .src_kind_o(src_kind_o), .src_channel_o(src_channel_o),
    .trigger_sel_o(trigger_sel_o), .trigger_err_o(trigger_err_o), .conv_start_o(conv_start_o),
    .ref_ready_o(ref_ready_o), .pin_out_buf_en_o(pin_out_buf_en_o), .pin_analog_o(pin_analog_o),
    .pin_amp_in_o(pin_amp_in_o), .pin_amp_out_o(pin_amp_out_o), .pin_convert_o(pin_convert_o),
    .port7_convert_o(port7_convert_o), .config_err_o(config_err_o)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  // One comparison; case inequality so an unknown never matches.
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
      n_mismatch++;
    end
  endtask

  // Write held until a rising edge sees no wait; one extra edge lets the decoded outputs land.
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bm = 1'b0, input logic [2:0] idx = 3'h0);
    logic w;
    bus_addr_i = a;
    bus_wdata_i = d;
    bus_bit_i = bm;
    bus_bit_idx_i = idx;
    bus_wr_i = 1'b1;
    waits = 0;
    do
    begin
      #1 w = bus_wait_o;
      @(posedge clk_i);
      waits++;
    end while (w === 1'b1 && waits < 4);
    @(negedge clk_i);
    bus_wr_i = 1'b0;
    bus_bit_i = 1'b0;
    @(negedge clk_i);
  endtask

  // Read takes one edge; data is compared once that edge has landed.
  // The strobe then rests for one edge, so two reads in a row never drive it twice at one instant.
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    bus_addr_i = a;
    bus_rd_i = 1'b1;
    @(negedge clk_i);
    bus_rd_i = 1'b0;
    chk($sformatf("read %h", a), bus_rdata_o, exp);
    @(negedge clk_i);
  endtask

  // Raises the run bit with optional one-cycle timer pulses, then counts start pulses.
  task automatic trig(input logic z, input logic o);
    conv_run_i = 1'b1;
    timer_x_zero_i = z;
    timer_x_one_i = o;
    @(negedge clk_i);
    timer_x_zero_i = 1'b0;
    timer_x_one_i = 1'b0;
    cnt = 32'(conv_start_o);
    repeat (4)
    begin
      @(negedge clk_i);
      cnt += 32'(conv_start_o);
    end
    conv_run_i = 1'b0;
    @(negedge clk_i);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // A hang counts as a mismatch; the longest test needs well under this many cycles.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    @(negedge clk_i);
    rd(16'hff0e, 8'h00);
    rd(16'hff22, 8'hff);
    rd(16'hff2e, 8'h00);
    rd(16'hff60, 8'h00);
    rd(16'hff00, 8'h00);
    chk("buf_en", pin_out_buf_en_o, 8'h00);
    chk("analog", pin_analog_o, 8'hff);
    $display("test reset done");

    wr(16'hff22, 8'h5a);
    chk("wait ff22", 8'(waits), 8'h01);
    rd(16'hff22, 8'h5a);
    chk("buf_en", pin_out_buf_en_o, 8'ha5);
    wr(16'hff22, 8'h01, 1'b1, 3'h0);
    rd(16'hff22, 8'h5b);
    // Every pin that a channel may pick is left in input mode.
    wr(16'hff22, 8'hff);
    $display("test direction done");

    // Codes 0..8 pick one pin each; code 9 is prohibited.
    for (int n = 0; n < 10; n++)
    begin
      wr(16'hff0e, 8'(n));
      chk("wait ff0e", 8'(waits), 8'h02);
      chk("kind", 8'(src_kind_o), 8'(n < 9 ? analog_sel_pkg::SRC_PIN : analog_sel_pkg::SRC_BAD));
      chk("channel", 8'(src_channel_o), 8'(n));
      chk("convert", pin_convert_o, n < 8 ? 8'h01 << n : 8'h00);
      chk("port7", 8'(port7_convert_o), 8'(n == 8));
      chk("err code", 8'(config_err_o), 8'(n == 9));
    end
    // A digital pin picked as channel is a deliberate misuse, so the flag must rise.
    wr(16'hff2e, 8'h08);
    wr(16'hff0e, 8'h03);
    chk("analog", pin_analog_o, 8'hf7);
    chk("convert", pin_convert_o, 8'h00);
    chk("err digital", 8'(config_err_o), 8'h01);
    wr(16'hff2e, 8'h00);
    $display("test channel done");

    wr(16'hff0e, 8'h45);
    chk("kind", 8'(src_kind_o), 8'(analog_sel_pkg::SRC_PGA));
    chk("convert", pin_convert_o, 8'h00);
    // The pick is set with the run bit low; the run bit waits for the settle time.
    wr(16'hff0e, 8'h85);
    chk("kind", 8'(src_kind_o), 8'(analog_sel_pkg::SRC_REF));
    chk("ref early", 8'(ref_ready_o), 8'h00);
    repeat (analog_sel_pkg::REF_SETTLE_CYCLES - 2) @(negedge clk_i);
    chk("ref before settle", 8'(ref_ready_o), 8'h00);
    @(negedge clk_i);
    chk("ref settled", 8'(ref_ready_o), 8'h01);
    trig(1'b0, 1'b0);
    chk("start ref", 8'(cnt), 8'h01);
    wr(16'hff0e, 8'hc9);
    chk("kind", 8'(src_kind_o), 8'(analog_sel_pkg::SRC_REF));
    wr(16'hff0e, 8'h00);
    chk("ref clear", 8'(ref_ready_o), 8'h00);
    $display("test source done");

    for (int t = 0; t < 4; t++)
    begin
      wr(16'hff0e, 8'(t << 4));
      chk("trig sel", 8'(trigger_sel_o), 8'(t));
      chk("trig err", 8'(trigger_err_o), 8'(t == 3));
    end
    // The mode is only changed with the run bit low.
    wr(16'hff0e, 8'h10);
    trig(1'b1, 1'b0);
    chk("start x0", 8'(cnt), 8'h01);
    trig(1'b0, 1'b1);
    chk("start x1 in x0", 8'(cnt), 8'h00);
    wr(16'hff0e, 8'h20);
    trig(1'b0, 1'b1);
    chk("start x1", 8'(cnt), 8'h01);
    wr(16'hff0e, 8'h00);
    trig(1'b0, 1'b0);
    chk("start sw", 8'(cnt), 8'h01);
    $display("test trigger done");

    // Amplifier configured with channel select at zero, so no route to it is open.
    wr(16'hff60, 8'hff);
    rd(16'hff60, 8'hc3);
    wr(16'hff60, 8'h80);
    chk("amp in", pin_amp_in_o, 8'h05);
    chk("amp out", 8'(pin_amp_out_o), 8'h01);
    chk("err", 8'(config_err_o), 8'h00);
    wr(16'hff60, 8'h40);
    chk("amp in", pin_amp_in_o, 8'h02);
    chk("amp out", 8'(pin_amp_out_o), 8'h00);
    wr(16'hff60, 8'hc0);
    chk("amp in", pin_amp_in_o, 8'h07);
    chk("amp out", 8'(pin_amp_out_o), 8'h01);
    // Upper direction bits stay one while pin 0 goes to output mode.
    wr(16'hff22, 8'hfe);
    chk("amp in", pin_amp_in_o, 8'h06);
    chk("err", 8'(config_err_o), 8'h01);
    wr(16'hff22, 8'h01, 1'b1, 3'h0);
    wr(16'hff60, 8'h80);
    wr(16'hff2e, 8'h02);
    chk("amp out", 8'(pin_amp_out_o), 8'h00);
    chk("err shared", 8'(config_err_o), 8'h01);
    $display("test amplifier done");
    finish_test();
  end
endmodule // tb
